// [hw/tsd_operand_decode.sv]
// tsd_operand_decode: decodes the third and fourth instruction doublewords
// into operand fields, one registered result per accepted instruction.
// assumes fetch supplies both words plus the instruction class on one cycle.
`timescale 1ns/100ps

// Operation
// - three-source: source-2 register from dw3 29:22, subregister from 21:19
// - three-source: source-2 swizzle from dw3 18:11, replication from bit 10
// - three-source: source-1 subregister is dw3 bit 0 then dw2 31:30
// - three-source: source-1 swizzle from dw2 29:22, replication from bit 21
// - three-source: source-0 register from dw2 19:12, subregister from 11:9
// - three-source: source-0 swizzle from dw2 8:1, replication from bit 0
// - an immediate source 0 or 1 takes the whole fourth word as value
// - send: fourth word bit 31 is end of thread
// - send with immediate source 1: low 31 bits are the message descriptor
// - direct aligned source 1: vertical stride from bits 24:21
// - direct aligned source 1: upper channel select from bits 19:16
// - direct aligned source 1: source modifier from bits 14:13
// - direct aligned source 1: register 12:5, subregister bit four from 4
// - direct aligned source 1: channel enable mask from bits 3:0
// - source-1 addressing fields are ignored when source 1 is immediate
module tsd_operand_decode
    import tsd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_valid,
    input wire logic [31:0] third_instruction_dword,
    input wire logic [31:0] fourth_instruction_dword,
    input wire logic is_three_src,
    input wire logic is_send,
    input wire logic src0_is_imm,
    input wire logic src1_is_imm,
    input wire logic sixteen_byte_aligned_mode,
    output logic out_valid,
    output logic tri_src0_register_number,
    output logic [7:0] tri_src0_register,
    output logic [2:0] tri_src0_subregister,
    output logic [7:0] tri_src0_swizzle,
    output logic tri_src0_replicate,
    output logic [2:0] tri_src1_subregister,
    output logic [7:0] tri_src1_swizzle,
    output logic tri_src1_replicate,
    output logic [7:0] tri_src2_register,
    output logic [2:0] tri_src2_subregister,
    output logic [7:0] tri_src2_swizzle,
    output logic tri_src2_replicate,
    output logic immediate_valid,
    output logic [31:0] immediate_word,
    output logic end_of_thread_flag,
    output logic descriptor_valid,
    output logic [30:0] message_descriptor_31b,
    output logic src1_fields_valid,
    output logic [3:0] src1_vertical_stride,
    output logic [3:0] src1_channel_select_upper,
    output logic [1:0] src1_source_modifier,
    output logic [7:0] src1_register_number,
    output logic src1_subregister_bit4,
    output logic [3:0] src1_channel_enable_mask,
    output logic mbz_violation
);

    logic ctrl_enable;
    logic ctrl_mbz_check;
    logic [7:0] w_s0_reg;
    logic [2:0] w_s0_sub;
    logic [7:0] w_s0_swz;
    logic w_s0_rep;
    logic [2:0] w_s1_sub;
    logic [7:0] w_s1_swz;
    logic w_s1_rep;
    logic [7:0] w_s2_reg;
    logic [2:0] w_s2_sub;
    logic [7:0] w_s2_swz;
    logic w_s2_rep;
    logic take;
    logic a16_direct;
    logic any_imm;
    logic next_out_valid;
    logic next_imm_valid;
    logic next_desc_valid;
    logic next_src1_valid;
    logic next_eot;
    logic next_mbz;
    logic [31:0] next_imm;
    logic [30:0] next_desc;
    logic [22:0] next_a16;
    logic [22:0] a16;
    logic [51:0] next_tri;
    logic [51:0] tri_bus;

    tsd_apb_regs u_regs (
        .clk(clk),
        .srst(srst),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .dec_pulse(out_valid),
        .mbz_pulse(out_valid && mbz_violation),
        .last_eot(end_of_thread_flag),
        .last_imm(immediate_valid),
        .ctrl_enable(ctrl_enable),
        .ctrl_mbz_check(ctrl_mbz_check)
    );

    tsd_three_src_fields u_tri (
        .dw2(third_instruction_dword),
        .dw3(fourth_instruction_dword),
        .src0_reg(w_s0_reg),
        .src0_sub(w_s0_sub),
        .src0_swz(w_s0_swz),
        .src0_rep(w_s0_rep),
        .src1_sub(w_s1_sub),
        .src1_swz(w_s1_swz),
        .src1_rep(w_s1_rep),
        .src2_reg(w_s2_reg),
        .src2_sub(w_s2_sub),
        .src2_swz(w_s2_swz),
        .src2_rep(w_s2_rep)
    );

    // instruction class qualifiers; three-source carries no immediate
    assign take = in_valid && ctrl_enable;
    assign any_imm = !is_three_src && (src0_is_imm || src1_is_imm);
    assign a16_direct = !is_three_src && sixteen_byte_aligned_mode && !any_imm;

    // next-value computation; fields hold between instructions
    always_comb
    begin
        next_out_valid = take;
        next_imm_valid = immediate_valid;
        next_desc_valid = descriptor_valid;
        next_src1_valid = src1_fields_valid;
        next_eot = end_of_thread_flag;
        next_mbz = mbz_violation;
        next_imm = immediate_word;
        next_desc = message_descriptor_31b;
        next_a16 = a16;
        next_tri = tri_bus;
        if (take)
        begin
            next_imm_valid = any_imm;
            // whole word is the operand value, no register fields apply
            next_imm = any_imm ? fourth_instruction_dword : 32'h0;
            next_eot = is_send && fourth_instruction_dword[TSD_EOT_BIT];
            // a register source 1 on send is address register zero, so no
            // descriptor is carried in the word in that case
            next_desc_valid = is_send && !is_three_src && src1_is_imm;
            next_desc = next_desc_valid ? fourth_instruction_dword[TSD_DESC_MSB:0] : 31'h0;
            next_src1_valid = a16_direct;
            // zeroed when not a direct aligned source 1 so stale fields never leak
            next_a16 = '0;
            if (a16_direct)
                next_a16 = {fourth_instruction_dword[TSD_VSTRIDE_MSB:TSD_VSTRIDE_LSB],
                            fourth_instruction_dword[TSD_CHSEL_MSB:TSD_CHSEL_LSB],
                            fourth_instruction_dword[TSD_SRCMOD_MSB:TSD_SRCMOD_LSB],
                            fourth_instruction_dword[TSD_REG_MSB:TSD_REG_LSB],
                            fourth_instruction_dword[TSD_SUB4_BIT],
                            fourth_instruction_dword[TSD_CHEN_MSB:TSD_CHEN_LSB]};
            next_tri = '0;
            if (is_three_src)
                next_tri = {w_s0_reg, w_s0_sub, w_s0_swz, w_s0_rep, w_s1_sub, w_s1_swz,
                            w_s1_rep, w_s2_reg, w_s2_sub, w_s2_swz, w_s2_rep};
            // flag only, the producer owns these bits; decode proceeds anyway
            next_mbz = 1'b0;
            if (ctrl_mbz_check && is_three_src)
                next_mbz = tsd_mbz_hit(fourth_instruction_dword, TSD_TRI_DW3_MBZ)
                           || tsd_mbz_hit(third_instruction_dword, TSD_TRI_DW2_MBZ);
            else if (ctrl_mbz_check && a16_direct)
                next_mbz = tsd_mbz_hit(fourth_instruction_dword, TSD_A16_MBZ);
        end
    end

    // registered outputs
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            out_valid <= 1'b0;
            immediate_valid <= 1'b0;
            descriptor_valid <= 1'b0;
            src1_fields_valid <= 1'b0;
            end_of_thread_flag <= 1'b0;
            mbz_violation <= 1'b0;
            immediate_word <= 32'h0;
            message_descriptor_31b <= 31'h0;
            a16 <= '0;
            tri_bus <= '0;
        end
        else
        begin
            out_valid <= next_out_valid;
            immediate_valid <= next_imm_valid;
            descriptor_valid <= next_desc_valid;
            src1_fields_valid <= next_src1_valid;
            end_of_thread_flag <= next_eot;
            mbz_violation <= next_mbz;
            immediate_word <= next_imm;
            message_descriptor_31b <= next_desc;
            a16 <= next_a16;
            tri_bus <= next_tri;
        end
    end

    // unpack the held field groups
    assign {tri_src0_register, tri_src0_subregister, tri_src0_swizzle, tri_src0_replicate,
            tri_src1_subregister, tri_src1_swizzle, tri_src1_replicate, tri_src2_register,
            tri_src2_subregister, tri_src2_swizzle, tri_src2_replicate} = tri_bus;
    assign {src1_vertical_stride, src1_channel_select_upper, src1_source_modifier,
            src1_register_number, src1_subregister_bit4, src1_channel_enable_mask} = a16;
    // nonzero register number flag kept for operand fetch bypass decisions
    assign tri_src0_register_number = |tri_src0_register;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence tri_taken;
        $past(in_valid && ctrl_enable && is_three_src);
    endsequence

    sequence a16_taken;
        $past(in_valid && ctrl_enable && !is_three_src && sixteen_byte_aligned_mode
              && !src0_is_imm && !src1_is_imm);
    endsequence

    src2_fields_a: assert property ((out_valid and tri_taken) |->
        tri_src2_register == $past(fourth_instruction_dword[29:22])
        && tri_src2_subregister == $past(fourth_instruction_dword[21:19]))
        else $error("source 2 register fields wrong");
    src2_swizzle_a: assert property ((out_valid and tri_taken) |->
        {tri_src2_swizzle, tri_src2_replicate} == $past(fourth_instruction_dword[18:10]))
        else $error("source 2 swizzle fields wrong");
    src1_split_a: assert property (tri_taken |->
        tri_src1_subregister == {$past(fourth_instruction_dword[0]),
                                 $past(third_instruction_dword[31:30])})
        else $error("source 1 split subregister wrong");
    src1_swizzle_a: assert property (tri_taken |->
        {tri_src1_swizzle, tri_src1_replicate} == $past(third_instruction_dword[29:21]))
        else $error("source 1 swizzle fields wrong");
    src0_reg_a: assert property (tri_taken |->
        {tri_src0_register, tri_src0_subregister} == $past(third_instruction_dword[19:9]))
        else $error("source 0 register fields wrong");
    src0_swizzle_a: assert property (tri_taken |->
        {tri_src0_swizzle, tri_src0_replicate} == $past(third_instruction_dword[8:0]))
        else $error("source 0 swizzle fields wrong");
    imm_word_a: assert property ($past(in_valid && ctrl_enable && !is_three_src
        && (src0_is_imm || src1_is_imm)) |->
        immediate_valid && immediate_word == $past(fourth_instruction_dword))
        else $error("immediate word not passed whole");
    send_eot_a: assert property ($past(in_valid && ctrl_enable) |->
        end_of_thread_flag == $past(is_send && fourth_instruction_dword[31]))
        else $error("end of thread flag wrong");
    send_desc_a: assert property ($past(in_valid && ctrl_enable && is_send
        && !is_three_src && src1_is_imm) |->
        descriptor_valid && message_descriptor_31b == $past(fourth_instruction_dword[30:0]))
        else $error("message descriptor wrong");
    a16_stride_a: assert property (a16_taken |->
        src1_vertical_stride == $past(fourth_instruction_dword[24:21]))
        else $error("vertical stride wrong");
    a16_chsel_a: assert property (a16_taken |->
        src1_channel_select_upper == $past(fourth_instruction_dword[19:16]))
        else $error("channel select wrong");
    a16_mod_a: assert property (a16_taken |->
        src1_source_modifier == $past(fourth_instruction_dword[14:13]))
        else $error("source modifier wrong");
    a16_reg_a: assert property (a16_taken |->
        {src1_register_number, src1_subregister_bit4} == $past(fourth_instruction_dword[12:4]))
        else $error("source 1 register wrong");
    a16_chen_a: assert property (a16_taken |->
        src1_channel_enable_mask == $past(fourth_instruction_dword[3:0]))
        else $error("channel enable wrong");
    imm_ignore_a: assert property (out_valid && immediate_valid |->
        !src1_fields_valid && a16 == '0)
        else $error("source 1 fields leak under immediate");
    mbz_flag_a: assert property ($past(in_valid && ctrl_enable && ctrl_mbz_check
        && a16_direct && |(fourth_instruction_dword & TSD_A16_MBZ)) |-> mbz_violation)
        else $error("must-be-zero violation missed");

    tri_seen_c: cover property (out_valid and tri_taken);
    send_desc_c: cover property (out_valid && descriptor_valid && end_of_thread_flag);
    a16_seen_c: cover property (out_valid && src1_fields_valid);
    mbz_seen_c: cover property (out_valid && mbz_violation);

endmodule : tsd_operand_decode

// [shared/tsd_pkg.sv]
// tsd_pkg: field positions, register map and reset values for the operand
// doubleword decoder. assumes 32-bit instruction doublewords from fetch.
package tsd_pkg;

    // apb register map, byte addresses
    localparam logic [7:0] TSD_REG_CTRL = 8'h00;
    localparam logic [7:0] TSD_REG_STATUS = 8'h04;
    localparam logic [7:0] TSD_REG_DEC_COUNT = 8'h08;
    localparam logic [7:0] TSD_REG_MBZ_COUNT = 8'h0c;
    localparam logic [31:0] TSD_CTRL_RESET = 32'h0000_0003;
    localparam int TSD_CTRL_ENABLE_BIT = 0;
    localparam int TSD_CTRL_MBZ_CHECK_BIT = 1;
    localparam int TSD_STAT_EOT_BIT = 0;
    localparam int TSD_STAT_IMM_BIT = 1;
    localparam int TSD_COUNT_W = 16;

    // three-source layout, fourth doubleword
    localparam int TSD_S2_REG_MSB = 29;
    localparam int TSD_S2_REG_LSB = 22;
    localparam int TSD_S2_SUB_MSB = 21;
    localparam int TSD_S2_SUB_LSB = 19;
    localparam int TSD_S2_SWZ_MSB = 18;
    localparam int TSD_S2_SWZ_LSB = 11;
    localparam int TSD_S2_REP_BIT = 10;
    localparam int TSD_S1_SUB_HI_BIT = 0;
    // three-source layout, third doubleword
    localparam int TSD_S1_SUB_LO_MSB = 31;
    localparam int TSD_S1_SUB_LO_LSB = 30;
    localparam int TSD_S1_SWZ_MSB = 29;
    localparam int TSD_S1_SWZ_LSB = 22;
    localparam int TSD_S1_REP_BIT = 21;
    localparam int TSD_S0_REG_MSB = 19;
    localparam int TSD_S0_REG_LSB = 12;
    localparam int TSD_S0_SUB_MSB = 11;
    localparam int TSD_S0_SUB_LSB = 9;
    localparam int TSD_S0_SWZ_MSB = 8;
    localparam int TSD_S0_SWZ_LSB = 1;
    localparam int TSD_S0_REP_BIT = 0;
    localparam logic [31:0] TSD_TRI_DW3_MBZ = 32'hc000_0000;
    localparam logic [31:0] TSD_TRI_DW2_MBZ = 32'h0010_0000;

    // fourth doubleword, send and direct sixteen-byte-aligned source 1
    localparam int TSD_EOT_BIT = 31;
    localparam int TSD_DESC_MSB = 30;
    localparam int TSD_VSTRIDE_MSB = 24;
    localparam int TSD_VSTRIDE_LSB = 21;
    localparam int TSD_CHSEL_MSB = 19;
    localparam int TSD_CHSEL_LSB = 16;
    localparam int TSD_SRCMOD_MSB = 14;
    localparam int TSD_SRCMOD_LSB = 13;
    localparam int TSD_REG_MSB = 12;
    localparam int TSD_REG_LSB = 5;
    localparam int TSD_SUB4_BIT = 4;
    localparam int TSD_CHEN_MSB = 3;
    localparam int TSD_CHEN_LSB = 0;
    localparam logic [31:0] TSD_A16_MBZ = 32'hfe10_8000;

    // true when any must-be-zero position of the word is set
    function automatic logic tsd_mbz_hit(input logic [31:0] word, input logic [31:0] mask);
        return |(word & mask);
    endfunction : tsd_mbz_hit

endpackage : tsd_pkg

// [hw/tsd_three_src_fields.sv]
// tsd_three_src_fields: pure field extraction for the three-source layout.
// assumes the caller registers the results; no clock here.
`timescale 1ns/100ps
module tsd_three_src_fields
    import tsd_pkg::*;
(
    input wire logic [31:0] dw2,
    input wire logic [31:0] dw3,
    output logic [7:0] src0_reg,
    output logic [2:0] src0_sub,
    output logic [7:0] src0_swz,
    output logic src0_rep,
    output logic [2:0] src1_sub,
    output logic [7:0] src1_swz,
    output logic src1_rep,
    output logic [7:0] src2_reg,
    output logic [2:0] src2_sub,
    output logic [7:0] src2_swz,
    output logic src2_rep
);

    // source 2 lives wholly in the fourth doubleword
    assign src2_reg = dw3[TSD_S2_REG_MSB:TSD_S2_REG_LSB];
    assign src2_sub = dw3[TSD_S2_SUB_MSB:TSD_S2_SUB_LSB];
    assign src2_swz = dw3[TSD_S2_SWZ_MSB:TSD_S2_SWZ_LSB];
    assign src2_rep = dw3[TSD_S2_REP_BIT];

    // source 1 subregister straddles the doubleword boundary, high bit first
    assign src1_sub = {dw3[TSD_S1_SUB_HI_BIT], dw2[TSD_S1_SUB_LO_MSB:TSD_S1_SUB_LO_LSB]};
    assign src1_swz = dw2[TSD_S1_SWZ_MSB:TSD_S1_SWZ_LSB];
    assign src1_rep = dw2[TSD_S1_REP_BIT];

    // source 0 lives wholly in the third doubleword
    assign src0_reg = dw2[TSD_S0_REG_MSB:TSD_S0_REG_LSB];
    assign src0_sub = dw2[TSD_S0_SUB_MSB:TSD_S0_SUB_LSB];
    assign src0_swz = dw2[TSD_S0_SWZ_MSB:TSD_S0_SWZ_LSB];
    assign src0_rep = dw2[TSD_S0_REP_BIT];

endmodule : tsd_three_src_fields

// [hw/tsd_apb_regs.sv]
// tsd_apb_regs: apb slave with the control word and decode statistics.
// assumes an apb master on clk; answers with zero wait states.
`timescale 1ns/100ps
module tsd_apb_regs
    import tsd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dec_pulse,
    input wire logic mbz_pulse,
    input wire logic last_eot,
    input wire logic last_imm,
    output logic ctrl_enable,
    output logic ctrl_mbz_check
);

    logic [31:0] ctrl;
    logic [TSD_COUNT_W-1:0] dec_count;
    logic [TSD_COUNT_W-1:0] mbz_count;
    logic [31:0] next_ctrl;
    logic [TSD_COUNT_W-1:0] next_dec_count;
    logic [TSD_COUNT_W-1:0] next_mbz_count;
    logic [31:0] next_prdata;
    logic mapped;

    // address decode; unmapped accesses answer with an error and read zero
    always_comb
    begin
        mapped = 1'b1;
        if (paddr == TSD_REG_CTRL)
            next_prdata = ctrl;
        else if (paddr == TSD_REG_STATUS)
            next_prdata = {30'h0, last_imm, last_eot};
        else if (paddr == TSD_REG_DEC_COUNT)
            next_prdata = {16'h0, dec_count};
        else if (paddr == TSD_REG_MBZ_COUNT)
            next_prdata = {16'h0, mbz_count};
        else
        begin
            next_prdata = 32'h0;
            mapped = 1'b0;
        end
    end

    // write takes effect only on the access edge; counters wrap silently
    always_comb
    begin
        next_ctrl = ctrl;
        if (psel && penable && pwrite && paddr == TSD_REG_CTRL)
            next_ctrl = {30'h0, pwdata[TSD_CTRL_MBZ_CHECK_BIT], pwdata[TSD_CTRL_ENABLE_BIT]};
        next_dec_count = dec_count + TSD_COUNT_W'(dec_pulse);
        next_mbz_count = mbz_count + TSD_COUNT_W'(mbz_pulse);
    end

    // read data is captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl <= TSD_CTRL_RESET;
            dec_count <= '0;
            mbz_count <= '0;
            prdata <= 32'h0;
        end
        else
        begin
            ctrl <= next_ctrl;
            dec_count <= next_dec_count;
            mbz_count <= next_mbz_count;
            if (psel && !penable && !pwrite)
                prdata <= next_prdata;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign ctrl_enable = ctrl[TSD_CTRL_ENABLE_BIT];
    assign ctrl_mbz_check = ctrl[TSD_CTRL_MBZ_CHECK_BIT];

endmodule : tsd_apb_regs

// [verif/tsd_fetch_model.sv]
// tsd_fetch_model: behavioural fetch stage that hands over instruction words.
// assumes the bench calls issue from its main sequence, one word pair per call.
`timescale 1ns/100ps
module tsd_fetch_model
    import tsd_pkg::*;
(
    input wire logic clk,
    output logic in_valid,
    output logic [31:0] third_instruction_dword,
    output logic [31:0] fourth_instruction_dword,
    output logic is_three_src,
    output logic is_send,
    output logic src0_is_imm,
    output logic src1_is_imm,
    output logic sixteen_byte_aligned_mode
);
    // idle before the first issue
    initial
    begin
        in_valid = 1'b0;
        third_instruction_dword = 32'h0;
        fourth_instruction_dword = 32'h0;
        {is_three_src, is_send, src0_is_imm, src1_is_imm, sixteen_byte_aligned_mode} = 5'h0;
    end

    // class bits c: three-source, send, src0 imm, src1 imm, aligned mode
    // callers keep must-be-zero bits clear except the final mbz probe; register-source sends are never issued
    task automatic issue(input logic [31:0] w2, input logic [31:0] w3, input logic [4:0] c);
        @(posedge clk);
        in_valid <= 1'b1;
        third_instruction_dword <= w2;
        fourth_instruction_dword <= w3;
        {is_three_src, is_send, src0_is_imm, src1_is_imm, sixteen_byte_aligned_mode} <= c;
        @(posedge clk);
        in_valid <= 1'b0;
        // stale words flip so nothing can lean on them once valid drops
        third_instruction_dword <= ~w2;
        fourth_instruction_dword <= ~w3;
    endtask : issue
endmodule : tsd_fetch_model

// [verif/tb_tsd_operand_decode.sv]
// tb_tsd_operand_decode: directed checks of the operand decoder and its registers.
// assumes a one-cycle decode answer; apb transfers wait on pready.
`timescale 1ns/100ps
module tb_tsd_operand_decode
    import tsd_pkg::*;
;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, in_valid, out_valid;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, third_instruction_dword, fourth_instruction_dword;
    logic is_three_src, is_send, src0_is_imm, src1_is_imm, sixteen_byte_aligned_mode;
    logic tri_src0_register_number, tri_src0_replicate, tri_src1_replicate, tri_src2_replicate;
    logic [7:0] tri_src0_register, tri_src0_swizzle, tri_src1_swizzle;
    logic [7:0] tri_src2_register, tri_src2_swizzle, src1_register_number;
    logic [2:0] tri_src0_subregister, tri_src1_subregister, tri_src2_subregister;
    logic immediate_valid, end_of_thread_flag, descriptor_valid, src1_fields_valid;
    logic [31:0] immediate_word;
    logic [30:0] message_descriptor_31b;
    logic [3:0] src1_vertical_stride, src1_channel_select_upper, src1_channel_enable_mask;
    logic [1:0] src1_source_modifier;
    logic src1_subregister_bit4, mbz_violation;
    logic [31:0] r, w2, w3;
    logic e;
    int error_cnt, checked;

    tsd_fetch_model i_tsd_fetch_model (.clk, .in_valid, .third_instruction_dword,
        .fourth_instruction_dword, .is_three_src, .is_send, .src0_is_imm, .src1_is_imm,
        .sixteen_byte_aligned_mode);

    tsd_operand_decode i_tsd_operand_decode (.clk, .srst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .in_valid, .third_instruction_dword,
        .fourth_instruction_dword, .is_three_src, .is_send, .src0_is_imm, .src1_is_imm,
        .sixteen_byte_aligned_mode, .out_valid, .tri_src0_register_number,
        .tri_src0_register, .tri_src0_subregister, .tri_src0_swizzle, .tri_src0_replicate,
        .tri_src1_subregister, .tri_src1_swizzle, .tri_src1_replicate, .tri_src2_register,
        .tri_src2_subregister, .tri_src2_swizzle, .tri_src2_replicate, .immediate_valid,
        .immediate_word, .end_of_thread_flag, .descriptor_valid, .message_descriptor_31b,
        .src1_fields_valid, .src1_vertical_stride, .src1_channel_select_upper,
        .src1_source_modifier, .src1_register_number, .src1_subregister_bit4,
        .src1_channel_enable_mask, .mbz_violation);

    // 50 ns period
    always #25 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one apb transfer; waits on pready rather than assuming zero wait states
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task stop_test;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // cuts a hang short; the whole run needs well under 200 cycles
    initial
    begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        $display("ERROR watchdog expected finish seen hang");
        stop_test();
    end

    // main sequence: registers, then three-source, aligned source 1, send and immediate classes
    initial
    begin
        clk = 1'b0; srst = 1'b1; paddr = 8'h00; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; pwdata = 32'h0; error_cnt = 0; checked = 0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, TSD_REG_CTRL, 32'h0, r, e);
        chk("ctrl", 32'h3, r);
        apb(1'b0, 8'h10, 32'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped rd", 32'h0, r);
        w2 = 32'h6ba5_9e53;
        w3 = 32'h2d6c_b4a1;
        i_tsd_fetch_model.issue(w2, w3, 5'h10);
        #1;
        chk("out_valid", 32'h1, {31'h0, out_valid});
        chk("s2 reg", {24'h0, w3[29:22]}, {24'h0, tri_src2_register});
        chk("s2 sub", {29'h0, w3[21:19]}, {29'h0, tri_src2_subregister});
        chk("s2 swz", {24'h0, w3[18:11]}, {24'h0, tri_src2_swizzle});
        chk("s2 rep", {31'h0, w3[10]}, {31'h0, tri_src2_replicate});
        chk("s1 sub", {29'h0, w3[0], w2[31:30]}, {29'h0, tri_src1_subregister});
        chk("s1 swz", {24'h0, w2[29:22]}, {24'h0, tri_src1_swizzle});
        chk("s1 rep", {31'h0, w2[21]}, {31'h0, tri_src1_replicate});
        chk("s0 reg", {24'h0, w2[19:12]}, {24'h0, tri_src0_register});
        chk("s0 regnz", 32'h1, {31'h0, tri_src0_register_number});
        chk("s0 sub", {29'h0, w2[11:9]}, {29'h0, tri_src0_subregister});
        chk("s0 swz", {24'h0, w2[8:1]}, {24'h0, tri_src0_swizzle});
        chk("s0 rep", {31'h0, w2[0]}, {31'h0, tri_src0_replicate});
        w3 = 32'h01a7_6b5c;
        i_tsd_fetch_model.issue(w2, w3, 5'h01);
        #1;
        chk("s1 valid1", 32'h1, {31'h0, src1_fields_valid});
        chk("vstride", {28'h0, w3[24:21]}, {28'h0, src1_vertical_stride});
        chk("chsel", {28'h0, w3[19:16]}, {28'h0, src1_channel_select_upper});
        chk("srcmod", {30'h0, w3[14:13]}, {30'h0, src1_source_modifier});
        chk("s1 reg", {24'h0, w3[12:5]}, {24'h0, src1_register_number});
        chk("s1 sub4", {31'h0, w3[4]}, {31'h0, src1_subregister_bit4});
        chk("chen", {28'h0, w3[3:0]}, {28'h0, src1_channel_enable_mask});
        w3 = 32'hc123_4567;
        i_tsd_fetch_model.issue(w2, w3, 5'h0a);
        #1;
        chk("imm valid", 32'h1, {31'h0, immediate_valid});
        chk("imm word", w3, immediate_word);
        chk("desc valid1", 32'h1, {31'h0, descriptor_valid});
        chk("eot", 32'h1, {31'h0, end_of_thread_flag});
        chk("desc", {1'b0, w3[30:0]}, {1'b0, message_descriptor_31b});
        chk("s1 valid", 32'h0, {31'h0, src1_fields_valid});
        w3 = 32'h7edc_ba98;
        i_tsd_fetch_model.issue(w2, w3, 5'h04);
        #1;
        chk("imm0 word", w3, immediate_word);
        chk("desc valid", 32'h0, {31'h0, descriptor_valid});
        chk("s1 reg imm", 32'h0, {24'h0, src1_register_number});
        apb(1'b1, TSD_REG_STATUS, 32'hff, r, e);
        apb(1'b0, TSD_REG_STATUS, 32'h0, r, e);
        chk("status", 32'h2, r);
        // decode disabled: the request is dropped and the fields hold
        apb(1'b1, TSD_REG_CTRL, 32'h2, r, e);
        i_tsd_fetch_model.issue(w2, 32'h8000_0001, 5'h0a);
        #1;
        chk("dis valid", 32'h0, {31'h0, out_valid});
        chk("dis hold", w3, immediate_word);
        apb(1'b1, TSD_REG_CTRL, 32'h3, r, e);
        i_tsd_fetch_model.issue(w2, 32'h0000_8000, 5'h01);
        #1;
        chk("mbz", 32'h1, {31'h0, mbz_violation});
        apb(1'b0, TSD_REG_DEC_COUNT, 32'h0, r, e);
        chk("dec count", 32'h5, r);
        apb(1'b0, TSD_REG_MBZ_COUNT, 32'h0, r, e);
        chk("mbz count", 32'h1, r);
        stop_test();
    end
endmodule : tb_tsd_operand_decode
